// ===== rtl/core_pointer_status_regs.sv
// Purpose: Stack pointer, data pointer and program status word of the core.
// Assumes: Core drives one special register access and one stack event per cycle.
// Notes: Hardware flag updates win over a software write in the same cycle.
//
// Summary of operation
// RQ1 - Push increments the stack pointer and stores at the incremented location.
// RQ2 - Stack pointer resets to 0x07.
// RQ3 - Data pointer word is high byte over low byte, sixteen bits.
// RQ4 - Carry set on add carry or subtract borrow, cleared by other arithmetic.
// RQ5 - Half carry set on nibble carry or borrow, cleared by other arithmetic.
// RQ6 - User flags at bits 5 and 1 change only by software writes.
// RQ7 - Bank select bits pick one of four eight-byte register banks.
// RQ8 - Range error set on signed overflow, product above 255, divide by zero.
// RQ9 - Range error cleared by those operations when no overflow occurs.
// RQ10 - Parity bit is read-only and shows odd accumulator ones.
// RQ11 - Software keeps reserved bits at zero.
// RQ12 - Addresses ending 0x0 or 0x8 accept bit writes; others only bytes.
// RQ13 - Data pointer bytes and status word reset to zero.
`timescale 1ns/10ps
module core_pointer_status_regs
    import core_regs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire sfr_access_t access_i,
    input wire logic [7:0] read_addr_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [7:0] accumulator_i,
    input wire arith_result_t arith_i,
    output logic [7:0] read_data_o,
    output logic read_hit_o,
    output logic [7:0] stack_pointer_o,
    output logic [7:0] stack_write_addr_o,
    output logic stack_write_en_o,
    output logic [15:0] data_pointer_word_o,
    output logic [7:0] program_status_word_o,
    output logic [4:0] bank_base_o
);

    // Stored registers and their next values.
    logic [7:0] stack_pointer_q;
    logic [7:0] stack_pointer_d;
    logic [7:0] data_pointer_low_q;
    logic [7:0] data_pointer_low_d;
    logic [7:0] data_pointer_high_q;
    logic [7:0] data_pointer_high_d;
    logic [7:0] psw_q;
    logic [7:0] psw_d;
    logic [7:0] push_addr_q;
    logic [7:0] push_addr_d;
    logic push_pending_q;
    logic push_pending_d;
    // Flag update requests from the arithmetic helper.
    logic carry_upd;
    logic carry_val;
    logic half_upd;
    logic half_val;
    logic range_upd;
    logic range_val;
    logic parity;
    // Status word as software sees it, with the live parity in bit 0.
    logic [7:0] psw_view;

    // Byte write with optional single-bit write, allowed only on bit-addressable addresses.
    function automatic logic [7:0] apply_write(input logic [7:0] old_val,
                                               input sfr_access_t acc);
        logic [7:0] res;
        res = old_val;
        if (acc.wr_en)
        begin
            res = acc.wdata;
        end
        else if (acc.bit_wr_en && (acc.addr[2:0] == BIT_ADDRESSABLE_LOW_BITS)) // [RQ12]
        begin
            res[acc.bit_sel] = acc.wdata[0];
        end
        return res;
    endfunction : apply_write

    // Hit test shared by every register. A bit write to a byte-only address is no access
    // at all, so it must not block a push or pop that arrives in the same cycle.
    function automatic logic is_target(input sfr_access_t acc, input logic [7:0] addr);
        logic legal_bit;
        legal_bit = acc.bit_wr_en && (acc.addr[2:0] == BIT_ADDRESSABLE_LOW_BITS); // [RQ12]
        return (acc.wr_en || legal_bit) && (acc.addr == addr);
    endfunction : is_target

    // Flag helper; kept apart so the arithmetic decode stays in one place.
    psw_flag_unit u_flags (
        .result_i(arith_i),
        .accumulator_i(accumulator_i),
        .carry_upd_o(carry_upd),
        .carry_val_o(carry_val),
        .half_upd_o(half_upd),
        .half_val_o(half_val),
        .range_upd_o(range_upd),
        .range_val_o(range_val),
        .parity_o(parity)
    );

    // Next-state for stack pointer; a push raises it before the data is stored.
    always_comb
    begin
        stack_pointer_d = stack_pointer_q;
        push_addr_d = push_addr_q;
        push_pending_d = 1'b0;
        if (is_target(access_i, STACK_POINTER_ADDR))
        begin
            stack_pointer_d = apply_write(stack_pointer_q, access_i);
        end
        else if (push_i)
        begin
            stack_pointer_d = stack_pointer_q + 8'h01; // [RQ1]
            push_addr_d = stack_pointer_q + 8'h01;
            push_pending_d = 1'b1; // [RQ1]
        end
        // Pop wraps below zero; the core must keep the stack in range.
        else if (pop_i)
        begin
            stack_pointer_d = stack_pointer_q - 8'h01;
        end
    end

    // Data pointer bytes are plain read-write storage.
    always_comb
    begin
        data_pointer_low_d = data_pointer_low_q;
        data_pointer_high_d = data_pointer_high_q;
        if (is_target(access_i, DATA_POINTER_LOW_ADDR))
        begin
            data_pointer_low_d = apply_write(data_pointer_low_q, access_i);
        end
        if (is_target(access_i, DATA_POINTER_HIGH_ADDR))
        begin
            data_pointer_high_d = apply_write(data_pointer_high_q, access_i);
        end
    end

    // Status word: software write first, then arithmetic flags override their own bits.
    always_comb
    begin
        psw_d = psw_q;
        if (is_target(access_i, PROGRAM_STATUS_WORD_ADDR))
        begin
            psw_d = apply_write(psw_view, access_i); // [RQ6] [RQ12]
        end
        if (carry_upd)
        begin
            psw_d[CARRY_BIT] = carry_val; // [RQ4]
        end
        if (half_upd)
        begin
            psw_d[HALF_CARRY_BIT] = half_val; // [RQ5]
        end
        if (range_upd)
        begin
            psw_d[RANGE_ERROR_BIT] = range_val; // [RQ8] [RQ9]
        end
        psw_d[PARITY_BIT] = 1'b0; // Parity is never stored; it is read live.
    end

    // Registers; reset values are constants only.
    // Parity has no storage, so it needs no reset value.
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            stack_pointer_q <= STACK_POINTER_RESET; // [RQ2]
            data_pointer_low_q <= DATA_POINTER_RESET; // [RQ13]
            data_pointer_high_q <= DATA_POINTER_RESET; // [RQ13]
            psw_q <= PROGRAM_STATUS_WORD_RESET; // [RQ13]
            push_addr_q <= STACK_POINTER_RESET;
            push_pending_q <= 1'b0;
        end
        else
        begin
            stack_pointer_q <= stack_pointer_d;
            data_pointer_low_q <= data_pointer_low_d;
            data_pointer_high_q <= data_pointer_high_d;
            psw_q <= psw_d;
            push_addr_q <= push_addr_d;
            push_pending_q <= push_pending_d;
        end
    end

    // Parity bit is read-only: the live accumulator parity replaces the stored bit.
    always_comb
    begin
        psw_view = psw_q;
        psw_view[PARITY_BIT] = parity; // [RQ10]
    end

    // Read mux; unmapped addresses return zero and no hit.
    // The read is combinational, so a write shows on the read port one cycle later.
    always_comb
    begin
        read_hit_o = 1'b1;
        case (read_addr_i)
            STACK_POINTER_ADDR: read_data_o = stack_pointer_q;
            DATA_POINTER_LOW_ADDR: read_data_o = data_pointer_low_q;
            DATA_POINTER_HIGH_ADDR: read_data_o = data_pointer_high_q;
            PROGRAM_STATUS_WORD_ADDR: read_data_o = psw_view;
            default:
            begin
                read_data_o = 8'h00;
                read_hit_o = 1'b0;
            end
        endcase
    end

    // The stack write goes out the cycle after the push, at the raised pointer.
    assign stack_write_addr_o = push_addr_q; // [RQ1]
    assign stack_write_en_o = push_pending_q; // [RQ1]
    assign stack_pointer_o = stack_pointer_q;
    assign data_pointer_word_o = {data_pointer_high_q, data_pointer_low_q}; // [RQ3]
    assign program_status_word_o = psw_view;
    // Bank base address is bank number times eight.
    assign bank_base_o = {psw_q[BANK_SELECT_HIGH_BIT], psw_q[BANK_SELECT_LOW_BIT],
                          3'h0}; // [RQ7]

endmodule : core_pointer_status_regs

// ===== rtl/core_regs_pkg.sv
// Purpose: Shared constants and carriers for the core pointer and status registers.
// Assumes: Special register space addresses are 8 bits, data is 8 bits.
// Notes: Field positions refer to the program status word.
package core_regs_pkg;

    // Special register space byte addresses.
    localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
    localparam logic [7:0] DATA_POINTER_LOW_ADDR = 8'h82;
    localparam logic [7:0] DATA_POINTER_HIGH_ADDR = 8'h83;
    localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hD0;

    // Reset values.
    localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
    localparam logic [7:0] DATA_POINTER_RESET = 8'h00;
    localparam logic [7:0] PROGRAM_STATUS_WORD_RESET = 8'h00;

    // Program status word field positions.
    localparam int CARRY_BIT = 7;
    localparam int HALF_CARRY_BIT = 6;
    localparam int USER_FLAG_ZERO_BIT = 5;
    localparam int BANK_SELECT_HIGH_BIT = 4;
    localparam int BANK_SELECT_LOW_BIT = 3;
    localparam int RANGE_ERROR_BIT = 2;
    localparam int USER_FLAG_ONE_BIT = 1;
    localparam int PARITY_BIT = 0;

    // Bit-addressable registers end in 0x0 or 0x8.
    localparam logic [2:0] BIT_ADDRESSABLE_LOW_BITS = 3'h0;

    // Register bank geometry inside internal data memory.
    localparam int BANK_SIZE_LOG2 = 3;

    // Arithmetic operation classes reported by the execution unit.
    typedef enum logic [6:0] {
        OP_NONE = 7'h01,
        OP_ADD = 7'h02,
        OP_ADDC = 7'h04,
        OP_SUBB = 7'h08,
        OP_MUL = 7'h10,
        OP_DIV = 7'h20,
        OP_OTHER = 7'h40
    } arith_op_t;

    // Result of one arithmetic operation as reported by the execution unit.
    typedef struct packed {
        arith_op_t op;
        logic carry;
        logic half_carry;
        logic signed_ovf;
        logic [15:0] product;
        logic divisor_zero;
    } arith_result_t;

    // Special register space access from the core.
    typedef struct packed {
        logic wr_en;
        logic bit_wr_en;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } sfr_access_t;

endpackage : core_regs_pkg

// ===== rtl/psw_flag_unit.sv
// Purpose: Computes the arithmetic flag updates of the program status word.
// Assumes: One arithmetic result is reported per cycle at most.
// Notes: Purely combinational; the register itself lives in the main module.
`timescale 1ns/10ps
module psw_flag_unit
    import core_regs_pkg::*;
(
    input wire arith_result_t result_i,
    input wire logic [7:0] accumulator_i,
    output logic carry_upd_o,
    output logic carry_val_o,
    output logic half_upd_o,
    output logic half_val_o,
    output logic range_upd_o,
    output logic range_val_o,
    output logic parity_o
);

    // Carry and half carry follow add, add-with-carry and subtract; other arithmetic clears them.
    always_comb
    begin
        carry_upd_o = 1'b0;
        carry_val_o = 1'b0;
        half_upd_o = 1'b0;
        half_val_o = 1'b0;
        range_upd_o = 1'b0;
        range_val_o = 1'b0;
        case (result_i.op)
            OP_ADD, OP_ADDC, OP_SUBB:
            begin
                carry_upd_o = 1'b1;
                carry_val_o = result_i.carry; // [RQ4]
                half_upd_o = 1'b1;
                half_val_o = result_i.half_carry; // [RQ5]
                range_upd_o = 1'b1;
                range_val_o = result_i.signed_ovf; // [RQ8] [RQ9]
            end
            OP_MUL:
            begin
                carry_upd_o = 1'b1; // [RQ4]
                half_upd_o = 1'b1; // [RQ5]
                range_upd_o = 1'b1;
                range_val_o = |result_i.product[15:8]; // [RQ8] [RQ9]
            end
            OP_DIV:
            begin
                carry_upd_o = 1'b1; // [RQ4]
                half_upd_o = 1'b1; // [RQ5]
                range_upd_o = 1'b1;
                range_val_o = result_i.divisor_zero; // [RQ8] [RQ9]
            end
            OP_OTHER:
            begin
                carry_upd_o = 1'b1; // [RQ4]
                half_upd_o = 1'b1; // [RQ5]
            end
            default:
            begin
                carry_upd_o = 1'b0;
            end
        endcase
    end

    // Parity is odd-count of accumulator ones, recomputed every cycle.
    assign parity_o = ^accumulator_i; // [RQ10]

endmodule : psw_flag_unit

// ===== tb/core_pointer_status_regs_asserts.sv
// Purpose: Port-level checks for the core pointer and status registers.
// Assumes: One clock domain; a low reset disables every check.
// Notes: Flag checks need no write guard, because hardware beats a same-cycle write.
`timescale 1ns/10ps
module core_pointer_status_regs_asserts
    import core_regs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire sfr_access_t access_i,
    input wire logic [7:0] read_addr_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [7:0] accumulator_i,
    input wire arith_result_t arith_i,
    input wire logic [7:0] read_data_o,
    input wire logic read_hit_o,
    input wire logic [7:0] stack_pointer_o,
    input wire logic [7:0] stack_write_addr_o,
    input wire logic stack_write_en_o,
    input wire logic [15:0] data_pointer_word_o,
    input wire logic [7:0] program_status_word_o,
    input wire logic [4:0] bank_base_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // A push only counts when no stack pointer write competes with it.
    sequence s_push;
        push_i && !(access_i.wr_en && access_i.addr == STACK_POINTER_ADDR);
    endsequence
    sequence s_add_like;
        arith_i.op inside {OP_ADD, OP_ADDC, OP_SUBB};
    endsequence
    property p_status_write;
        logic [6:0] v;
        (access_i.wr_en && access_i.addr == PROGRAM_STATUS_WORD_ADDR && arith_i.op == OP_NONE,
            v = access_i.wdata[7:1]) |=> program_status_word_o[7:1] == v;
    endproperty
    property p_mul_range;
        logic v;
        (arith_i.op == OP_MUL, v = |arith_i.product[15:8])
            |=> program_status_word_o[2] == v && program_status_word_o[7:6] == 2'h0;
    endproperty
    chk_push_incr:
    assert property (s_push |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01)
        else $error("push did not step the stack pointer");
    chk_push_store:
    assert property (s_push |=> stack_write_en_o && stack_write_addr_o == stack_pointer_o)
        else $error("push store not at new top");
    chk_read_high:
    assert property (read_addr_i == DATA_POINTER_HIGH_ADDR
        |-> read_hit_o && read_data_o == data_pointer_word_o[15:8])
        else $error("pointer high byte mismatch");
    chk_parity_live:
    assert property (program_status_word_o[0] == ^accumulator_i)
        else $error("parity bit wrong");
    chk_bank_map:
    assert property (bank_base_o == {program_status_word_o[4:3], 3'h0})
        else $error("bank base wrong");
    chk_add_flags:
    assert property (s_add_like |=> program_status_word_o[7:6]
        == {$past(arith_i.carry), $past(arith_i.half_carry)}
        && program_status_word_o[2] == $past(arith_i.signed_ovf))
        else $error("add flags wrong");
    chk_mul_range:
    assert property (p_mul_range) else $error("multiply flags wrong");
    chk_div_range:
    assert property (arith_i.op == OP_DIV
        |=> program_status_word_o[2] == $past(arith_i.divisor_zero))
        else $error("divide flag wrong");
    chk_user_flags:
    assert property (!(access_i.addr == PROGRAM_STATUS_WORD_ADDR
        && (access_i.wr_en || access_i.bit_wr_en))
        |=> $stable(program_status_word_o[5]) && $stable(program_status_word_o[1]))
        else $error("user flag changed");
    chk_status_write:
    assert property (p_status_write) else $error("status write lost");
    chk_bit_ignored:
    assert property (access_i.bit_wr_en && !access_i.wr_en && !push_i && !pop_i
        && access_i.addr == STACK_POINTER_ADDR |=> $stable(stack_pointer_o))
        else $error("bit write hit stack pointer");
endmodule : core_pointer_status_regs_asserts

// ===== tb/core_pointer_status_regs_tb_top.sv
// Purpose: Self-checking bench for the core pointer and status registers.
// Assumes: Inputs change at the falling edge, where outputs are compared too.
// Notes: A bench model tracks every register; random traffic uses a fixed seed.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module core_pointer_status_regs_tb_top;
    import core_regs_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    sfr_access_t access_i = '0;
    logic [7:0] read_addr_i = 8'h00;
    logic push_i = 1'b0;
    logic pop_i = 1'b0;
    logic [7:0] accumulator_i = 8'h00;
    arith_result_t arith_i = '0;
    logic [7:0] read_data_o, stack_pointer_o, stack_write_addr_o, program_status_word_o;
    logic read_hit_o, stack_write_en_o;
    logic [15:0] data_pointer_word_o;
    logic [4:0] bank_base_o;
    logic [7:0] m_sp, m_dpl, m_dph, m_wa;
    logic [7:1] m_psw;
    logic m_we;
    int err_count = 0;
    int cmp_count = 0;
    logic [7:0] addrs [6] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hD8, 8'h84};
    // Free-running core clock.
    always #5 sys_clk_i = ~sys_clk_i;
    core_pointer_status_regs uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .access_i(access_i), .read_addr_i(read_addr_i), .push_i(push_i), .pop_i(pop_i),
        .accumulator_i(accumulator_i), .arith_i(arith_i), .read_data_o(read_data_o),
        .read_hit_o(read_hit_o), .stack_pointer_o(stack_pointer_o),
        .stack_write_addr_o(stack_write_addr_o), .stack_write_en_o(stack_write_en_o),
        .data_pointer_word_o(data_pointer_word_o),
        .program_status_word_o(program_status_word_o), .bank_base_o(bank_base_o));
    // Expected combinational read; unmapped places read as zero.
    function automatic logic [7:0] exp_read(input logic [7:0] a);
        case (a)
            STACK_POINTER_ADDR: return m_sp;
            DATA_POINTER_LOW_ADDR: return m_dpl;
            DATA_POINTER_HIGH_ADDR: return m_dph;
            PROGRAM_STATUS_WORD_ADDR: return {m_psw, ^accumulator_i};
            default: return 8'h00;
        endcase
    endfunction : exp_read
    function automatic sfr_access_t wr(input logic [7:0] ad, input logic [7:0] d);
        return {1'b1, 1'b0, ad, 3'h0, d};
    endfunction : wr
    function automatic arith_result_t ar(input arith_op_t o, input logic [15:0] p);
        return {o, 3'h7, p, 1'b1};
    endfunction : ar
    task automatic check_all();
        `CHK("stack", m_sp, stack_pointer_o)
        `CHK("data_pointer_word", {m_dph, m_dpl}, data_pointer_word_o)
        `CHK("status", {m_psw, ^accumulator_i}, program_status_word_o)
        `CHK("bank", {m_psw[4:3], 3'h0}, bank_base_o)
        `CHK("push en", m_we, stack_write_en_o)
        `CHK("push addr", m_wa, stack_write_addr_o)
        `CHK("read", exp_read(read_addr_i), read_data_o)
        `CHK("hit", (read_addr_i inside {STACK_POINTER_ADDR, DATA_POINTER_LOW_ADDR,
            DATA_POINTER_HIGH_ADDR, PROGRAM_STATUS_WORD_ADDR}), read_hit_o)
    endtask : check_all
    // Drive one cycle, advance the model as the hardware should, then compare.
    task automatic step(input sfr_access_t a, input logic pu, input logic po,
        input arith_result_t r);
        logic sp_wr;
        access_i = a;
        push_i = pu;
        pop_i = po;
        arith_i = r;
        accumulator_i = 8'($urandom);
        read_addr_i = addrs[$urandom % 6];
        sp_wr = a.wr_en && a.addr == STACK_POINTER_ADDR;
        m_we = pu && !sp_wr;
        if (m_we)
            m_wa = m_sp + 8'h01;
        if (!sp_wr)
            m_sp = pu ? m_sp + 8'h01 : (po ? m_sp - 8'h01 : m_sp);
        if (a.wr_en)
            case (a.addr)
                STACK_POINTER_ADDR: m_sp = a.wdata;
                DATA_POINTER_LOW_ADDR: m_dpl = a.wdata;
                DATA_POINTER_HIGH_ADDR: m_dph = a.wdata;
                PROGRAM_STATUS_WORD_ADDR: m_psw = a.wdata[7:1];
                default: ;
            endcase
        else if (a.bit_wr_en && a.addr == PROGRAM_STATUS_WORD_ADDR && a.bit_sel != 3'h0)
            m_psw[a.bit_sel] = a.wdata[0];
        if (r.op != OP_NONE)
            m_psw[7:6] = 2'h0;
        case (r.op)
            OP_ADD, OP_ADDC, OP_SUBB: {m_psw[7:6], m_psw[2]} = {r.carry, r.half_carry, r.signed_ovf};
            OP_MUL: m_psw[2] = |r.product[15:8];
            OP_DIV: m_psw[2] = r.divisor_zero;
            default: ;
        endcase
        @(negedge sys_clk_i);
        check_all();
    endtask : step
    task automatic rand_step();
        sfr_access_t a;
        arith_result_t r;
        a = 21'($urandom);
        r = 27'($urandom);
        a.addr = addrs[$urandom % 6]; // These registers hold no reserved bit.
        a.bit_wr_en = a.bit_wr_en && !a.wr_en;
        r.op = arith_op_t'(7'h01 << ($urandom % 7));
        r.product[15:8] = r.product[15:8] & {8{r.carry}};
        step(a, 1'($urandom), 1'($urandom), r);
    endtask : rand_step
    // Reset is held for three cycles and checked while it is still asserted.
    task automatic do_reset();
        reset_n_i = 1'b0;
        {m_sp, m_wa, m_dpl, m_dph, m_psw, m_we} = {8'h07, 8'h07, 16'h0000, 7'h00, 1'b0};
        {access_i, push_i, pop_i} = '0;
        arith_i = ar(OP_NONE, 16'h0000);
        read_addr_i = STACK_POINTER_ADDR;
        repeat (3) @(negedge sys_clk_i);
        check_all();
        reset_n_i = 1'b1;
    endtask : do_reset
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // Corner cases first, then random traffic across a second reset.
    initial
    begin
        void'($urandom(32'hEC48));
        do_reset();
        step(wr(STACK_POINTER_ADDR, 8'hFE), 1'b1, 1'b0, ar(OP_NONE, 16'h0000));
        step('0, 1'b1, 1'b0, ar(OP_NONE, 16'h0000));
        step('0, 1'b1, 1'b1, ar(OP_NONE, 16'h0000));
        step(wr(PROGRAM_STATUS_WORD_ADDR, 8'hFE), 1'b0, 1'b0, ar(OP_OTHER, 16'h0000));
        step(wr(PROGRAM_STATUS_WORD_ADDR, 8'h18), 1'b0, 1'b0, ar(OP_NONE, 16'h0000));
        step('0, 1'b0, 1'b0, ar(OP_MUL, 16'h0100));
        step('0, 1'b0, 1'b0, ar(OP_MUL, 16'h00FF));
        step('0, 1'b0, 1'b0, ar(OP_DIV, 16'h0000));
        repeat (3000) rand_step();
        do_reset();
        repeat (500) rand_step();
        give_verdict();
    end
    // Watchdog in case the run ever stalls.
    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule : core_pointer_status_regs_tb_top
bind core_pointer_status_regs core_pointer_status_regs_asserts chk (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .access_i(access_i), .read_addr_i(read_addr_i),
    .push_i(push_i), .pop_i(pop_i), .accumulator_i(accumulator_i), .arith_i(arith_i),
    .read_data_o(read_data_o), .read_hit_o(read_hit_o), .stack_pointer_o(stack_pointer_o),
    .stack_write_addr_o(stack_write_addr_o), .stack_write_en_o(stack_write_en_o),
    .data_pointer_word_o(data_pointer_word_o),
    .program_status_word_o(program_status_word_o), .bank_base_o(bank_base_o));
